//--- verilog/mlcd_defs.vh
// Constants for the monochrome panel refresh controller
`ifndef MLCD_DEFS_VH
`define MLCD_DEFS_VH

// Fixed video buffer base address
`define MLCD_VIDEO_BASE 32'hC000_0000

// Control word field positions
`define MLCD_FSIZE_MSB 12
`define MLCD_FSIZE_LSB 0
`define MLCD_LLEN_MSB 18
`define MLCD_LLEN_LSB 13
`define MLCD_PRESC_MSB 23
`define MLCD_PRESC_LSB 19
`define MLCD_BPP_MSB 25
`define MLCD_BPP_LSB 24
`define MLCD_EN_BIT 31

// Control and palette reset values
`define MLCD_CTRL_RST 32'h0000_0000
`define MLCD_PALETTE_RST 32'h0000_0000

// Pixel depth encodings
`define MLCD_BPP_1 2'h0
`define MLCD_BPP_2 2'h1
`define MLCD_BPP_4 2'h2

// Pixel step per depth, in bits
`define MLCD_STEP_1 5'h01
`define MLCD_STEP_2 5'h02
`define MLCD_STEP_4 5'h04

// Panel line granule: sixteen pixels
`define MLCD_LINE_GRAN_SHIFT 4
`define MLCD_LINE_LOW_ONES 4'hF

// Pixel rate range in kHz
`define MLCD_PIX_MAX_KHZ 18432
`define MLCD_PIX_MIN_KHZ 576
`define MLCD_PRESC_MAX ((`MLCD_PIX_MAX_KHZ / `MLCD_PIX_MIN_KHZ) - 1)

// FIFO and burst geometry
`define MLCD_FIFO_DEPTH 9
`define MLCD_FIFO_AW 4
`define MLCD_FIFO_LAST 4'h8
`define MLCD_QUAD_BEATS 3'h4
`define MLCD_QUAD_SHIFT 4
`define MLCD_WORD_IN_QUAD_LAST 2'h3

`endif

//--- verilog/mlcd_fifo.v
// Nine-entry word FIFO with registered read data
`timescale 1ns/1ps
`include "mlcd_defs.vh"
module mlcd_fifo (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  input wire flush_i,
  // Write side
  input wire wr_en_i,
  input wire [31:0] wdata_i,
  // Read side
  input wire rd_en_i,
  output reg [31:0] rdata_o,
  output reg [3:0] count_o
);

  reg [31:0] mem_reg [0:`MLCD_FIFO_DEPTH-1]; // Storage words
  reg [3:0] wptr_reg; // Write pointer
  reg [3:0] rptr_reg; // Read pointer
  wire do_wr; // Accepted write
  wire do_rd; // Accepted read

  // Writes past full and reads past empty are dropped
  assign do_wr = wr_en_i && (count_o != `MLCD_FIFO_LAST + 4'h1);
  assign do_rd = rd_en_i && (count_o != 4'h0);

  // Pointer step with wrap at nine entries
  function [3:0] mlcd_inc;
    input [3:0] p;
    begin
      if (p == `MLCD_FIFO_LAST) begin
        mlcd_inc = 4'h0;
      end else begin
        mlcd_inc = p + 4'h1;
      end
    end
  endfunction

  // Storage writes, no reset needed on data
  always @(posedge clk_i) begin
    if (do_wr) begin
      mem_reg[wptr_reg] <= wdata_i;
    end
  end

  // Pointers, level and registered read data
  always @(posedge clk_i) begin
    if (!nrst_i || flush_i) begin
      wptr_reg <= 4'h0;
      rptr_reg <= 4'h0;
      count_o <= 4'h0;
      rdata_o <= 32'h0000_0000;
    end else begin
      if (do_wr) begin
        wptr_reg <= mlcd_inc(wptr_reg);
      end
      if (do_rd) begin
        rptr_reg <= mlcd_inc(rptr_reg);
        rdata_o <= mem_reg[rptr_reg];
      end
      if (do_wr && !do_rd) begin
        count_o <= count_o + 4'h1;
      end else if (do_rd && !do_wr) begin
        count_o <= count_o - 4'h1;
      end
    end
  end

endmodule

//--- verilog/mlcd_refresh.v
// Monochrome panel refresh controller: DMA fetch, unpack, palette, timing
//
// Functional notes
// - Drives panel control signals directly, no glue
// - Line length 16 to 1024, 16-pixel steps
// - Frame size programmable, up to 128 Kbytes
// - Nine-entry FIFO refilled by DMA requests
// - Video buffer at fixed DRAM base address
// - Pixel depth 1, 2 or 4 bits
// - Screen read as one contiguous block
// - First pixel in least significant bits
// - Pixel rate programmable 18.432 MHz to 576 kHz
// - Parameters set by single control register write
// - Pixel mapped through palette to 16 levels
// - Palette is two 32-bit written registers
// - Refresh rate independent of depth; fetch scales
// - Each request answered by a DMA quad word
`timescale 1ns/1ps
`include "mlcd_defs.vh"
module mlcd_refresh (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Control register write port
  input wire ctrl_wr_i,
  input wire [31:0] ctrl_data_i,
  // Palette register write ports
  input wire palette_lo_wr_i,
  input wire palette_hi_wr_i,
  input wire [31:0] palette_data_i,
  // Pixel reference clock from outside
  input wire pix_ref_i,
  // DMA request and data return
  output reg dma_req_o,
  output reg [31:0] dma_addr_o,
  input wire dma_valid_i,
  input wire [31:0] dma_data_i,
  // Panel pins
  output reg [3:0] lcd_data_o,
  output reg lcd_cp_o,
  output reg lcd_lp_o,
  output reg lcd_flm_o,
  output reg lcd_m_o,
  // Status
  output reg underrun_o,
  output reg [31:0] ctrl_o
);

  // Pixel engine states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LOAD = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [31:0] panel_control_reg; // Operating parameters
  reg [31:0] palette_lo_reg; // Palette entries 0..7
  reg [31:0] palette_hi_reg; // Palette entries 8..15
  reg ref_s1_reg; // Synchroniser first stage
  reg ref_s2_reg; // Synchroniser second stage
  reg ref_d_reg; // Edge detector history
  reg [4:0] presc_reg; // Reference edge counter
  reg pix_tick_reg; // One pixel period elapsed
  reg [2:0] beats_reg; // Beats still due from DMA
  reg [12:0] fetch_q_reg; // Next quad word to fetch
  reg [14:0] pop_w_reg; // Next word index to unpack
  reg last_reg; // Word in hand ends the frame
  reg [1:0] state_reg; // Pixel engine state
  reg [1:0] state_next;
  reg [31:0] word_reg; // Word being unpacked
  reg [4:0] bitpos_reg; // Bit offset of next pixel
  reg [9:0] x_reg; // Pixel position in line
  reg first_line_reg; // Showing first line of frame
  reg start_reg; // Next pixel opens a frame
  reg fifo_rd; // Pop request
  wire [31:0] fifo_rdata; // Popped word
  wire [3:0] fifo_count; // FIFO level
  wire en; // Controller enabled
  wire [12:0] fsize_q; // Last quad of frame
  wire [9:0] line_last; // Last pixel index of line
  wire [4:0] presc; // Reference edges per pixel, less one
  wire [1:0] bpp; // Pixel depth code
  wire [4:0] step; // Bits per pixel
  wire ref_rise; // Reference clock rising edge
  wire word_done; // Current pixel ends the word
  wire [3:0] pix_val; // Raw pixel value
  wire can_req; // Room for one more quad

  // Control fields
  assign en = panel_control_reg[`MLCD_EN_BIT];
  assign fsize_q = panel_control_reg[`MLCD_FSIZE_MSB:`MLCD_FSIZE_LSB];
  assign presc = panel_control_reg[`MLCD_PRESC_MSB:`MLCD_PRESC_LSB];
  assign bpp = panel_control_reg[`MLCD_BPP_MSB:`MLCD_BPP_LSB];
  // Line length is (field + 1) times sixteen
  assign line_last = {panel_control_reg[`MLCD_LLEN_MSB:`MLCD_LLEN_LSB],
                      `MLCD_LINE_LOW_ONES};

  // Bit width of one pixel at the chosen depth
  function [4:0] mlcd_step;
    input [1:0] code;
    begin
      if (code == `MLCD_BPP_1) begin
        mlcd_step = `MLCD_STEP_1;
      end else if (code == `MLCD_BPP_2) begin
        mlcd_step = `MLCD_STEP_2;
      end else begin
        mlcd_step = `MLCD_STEP_4;
      end
    end
  endfunction

  // Extract one pixel, low bits first, zero extended
  function [3:0] mlcd_pixel;
    input [31:0] w;
    input [4:0] pos;
    input [1:0] code;
    reg [31:0] sh;
    begin
      sh = w >> pos;
      if (code == `MLCD_BPP_1) begin
        mlcd_pixel = {3'h0, sh[0]};
      end else if (code == `MLCD_BPP_2) begin
        mlcd_pixel = {2'h0, sh[1:0]};
      end else begin
        mlcd_pixel = sh[3:0];
      end
    end
  endfunction

  assign step = mlcd_step(bpp);
  assign pix_val = mlcd_pixel(word_reg, bitpos_reg, bpp);
  assign word_done = ((bitpos_reg + step) & 5'h1F) == 5'h00;
  assign ref_rise = ref_s2_reg && !ref_d_reg;
  // Request only when a whole quad fits beside what is due
  assign can_req = ({1'b0, fifo_count} + {2'h0, beats_reg}
                    + {2'h0, `MLCD_QUAD_BEATS}) <= `MLCD_FIFO_DEPTH;

  // Word buffer between DMA and the unpacker
  mlcd_fifo u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .flush_i(!en),
    .wr_en_i(dma_valid_i && en),
    .wdata_i(dma_data_i),
    .rd_en_i(fifo_rd),
    .rdata_o(fifo_rdata),
    .count_o(fifo_count)
  );

  // Software writes to control and palette
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      panel_control_reg <= `MLCD_CTRL_RST;
      palette_lo_reg <= `MLCD_PALETTE_RST;
      palette_hi_reg <= `MLCD_PALETTE_RST;
      ctrl_o <= `MLCD_CTRL_RST;
    end else begin
      if (ctrl_wr_i) begin
        panel_control_reg <= ctrl_data_i;
        ctrl_o <= ctrl_data_i;
      end
      if (palette_lo_wr_i) begin
        palette_lo_reg <= palette_data_i;
      end
      if (palette_hi_wr_i) begin
        palette_hi_reg <= palette_data_i;
      end
    end
  end

  // Reference clock synchroniser and pixel divider
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_d_reg <= 1'b0;
      presc_reg <= 5'h00;
      pix_tick_reg <= 1'b0;
    end else begin
      ref_s1_reg <= pix_ref_i;
      ref_s2_reg <= ref_s1_reg;
      ref_d_reg <= ref_s2_reg;
      pix_tick_reg <= 1'b0;
      if (!en) begin
        presc_reg <= 5'h00;
      end else if (ref_rise) begin
        // Divide reference by presc + 1, independent of depth
        if (presc_reg >= presc) begin
          presc_reg <= 5'h00;
          pix_tick_reg <= 1'b1;
        end else begin
          presc_reg <= presc_reg + 5'h01;
        end
      end
    end
  end

  // DMA request: one quad per request, address wraps per frame
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      dma_req_o <= 1'b0;
      dma_addr_o <= `MLCD_VIDEO_BASE;
      beats_reg <= 3'h0;
      fetch_q_reg <= 13'h0000;
    end else begin
      if (dma_valid_i && beats_reg != 3'h0) begin
        beats_reg <= beats_reg - 3'h1;
        dma_req_o <= 1'b0;
      end
      if (!en) begin
        // Disabled: fetch pointer back to the buffer base
        dma_req_o <= 1'b0;
        fetch_q_reg <= 13'h0000;
        dma_addr_o <= `MLCD_VIDEO_BASE;
      end else if (!dma_req_o && beats_reg == 3'h0 && can_req) begin
        dma_req_o <= 1'b1;
        beats_reg <= `MLCD_QUAD_BEATS;
        dma_addr_o <= `MLCD_VIDEO_BASE
                      + {15'h0000, fetch_q_reg, 4'h0};
        if (fetch_q_reg >= fsize_q) begin
          fetch_q_reg <= 13'h0000;
        end else begin
          fetch_q_reg <= fetch_q_reg + 13'h0001;
        end
      end
    end
  end

  // Pixel engine next state and pop decision
  always @* begin
    state_next = state_reg;
    fifo_rd = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // Wait for a word in the FIFO
        if (en && fifo_count != 4'h0) begin
          fifo_rd = 1'b1;
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // Popped word lands in the FIFO output register
        state_next = ST_RUN;
      end
      ST_RUN: begin
        // Fetch the next word when this one is spent
        if (pix_tick_reg && word_done) begin
          if (fifo_count != 4'h0) begin
            fifo_rd = 1'b1;
            state_next = ST_LOAD;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!en) begin
      fifo_rd = 1'b0;
      state_next = ST_IDLE;
    end
  end

  // Pixel engine registers and panel outputs
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      word_reg <= 32'h0000_0000;
      bitpos_reg <= 5'h00;
      pop_w_reg <= 15'h0000;
      last_reg <= 1'b0;
      x_reg <= 10'h000;
      first_line_reg <= 1'b0;
      start_reg <= 1'b1;
      lcd_data_o <= 4'h0;
      lcd_cp_o <= 1'b0;
      lcd_lp_o <= 1'b0;
      lcd_flm_o <= 1'b0;
      lcd_m_o <= 1'b0;
      underrun_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      lcd_cp_o <= 1'b0;
      lcd_lp_o <= 1'b0;
      lcd_flm_o <= first_line_reg;
      // Write of the control register clears the underrun flag
      if (ctrl_wr_i) begin
        underrun_o <= 1'b0;
      end
      if (!en) begin
        // Disabled: restart at the top of a frame
        pop_w_reg <= 15'h0000;
        last_reg <= 1'b0;
        x_reg <= 10'h000;
        first_line_reg <= 1'b0;
        start_reg <= 1'b1;
        lcd_data_o <= 4'h0;
      end else begin
        if (fifo_rd) begin
          // Count words so the frame end is known
          last_reg <= (pop_w_reg == {fsize_q, `MLCD_WORD_IN_QUAD_LAST});
          if (pop_w_reg == {fsize_q, `MLCD_WORD_IN_QUAD_LAST}) begin
            pop_w_reg <= 15'h0000;
          end else begin
            pop_w_reg <= pop_w_reg + 15'h0001;
          end
        end
        if (state_reg == ST_LOAD) begin
          word_reg <= fifo_rdata;
          bitpos_reg <= 5'h00;
        end
        if (state_reg != ST_RUN && pix_tick_reg) begin
          // Pixel due but no data in hand; set wins over clear
          underrun_o <= 1'b1;
        end
        if (state_reg == ST_RUN && pix_tick_reg) begin
          // Palette lookup to one of sixteen levels
          if (pix_val[3]) begin
            lcd_data_o <= palette_hi_reg[{pix_val[2:0], 2'h0} +: 4];
          end else begin
            lcd_data_o <= palette_lo_reg[{pix_val[2:0], 2'h0} +: 4];
          end
          lcd_cp_o <= 1'b1;
          bitpos_reg <= bitpos_reg + step;
          if (start_reg) begin
            // First pixel of a frame marks the first line
            start_reg <= 1'b0;
            first_line_reg <= 1'b1;
            lcd_flm_o <= 1'b1;
            lcd_m_o <= !lcd_m_o;
          end
          if (x_reg >= line_last) begin
            x_reg <= 10'h000;
            lcd_lp_o <= 1'b1;
            first_line_reg <= 1'b0;
          end else begin
            x_reg <= x_reg + 10'h001;
          end
          if (word_done && last_reg) begin
            // Frame ends on its last word; next pixel restarts
            start_reg <= 1'b1;
            x_reg <= 10'h000;
            lcd_lp_o <= 1'b1;
            first_line_reg <= 1'b0;
          end
        end
      end
    end
  end

endmodule

//--- verif/mlcd_refresh_properties.sv
// Port-level checks for the panel refresh controller
`timescale 1ns/1ps
module mlcd_refresh_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control and DMA
  input wire logic ctrl_wr_i,
  input wire logic [31:0] ctrl_data_i,
  input wire logic [31:0] ctrl_o,
  input wire logic dma_req_o,
  input wire logic [31:0] dma_addr_o,
  input wire logic dma_valid_i,
  // Panel and status
  input wire logic [3:0] lcd_data_o,
  input wire logic lcd_cp_o,
  input wire logic lcd_lp_o,
  input wire logic lcd_flm_o,
  input wire logic lcd_m_o,
  input wire logic underrun_o
);
  // One domain, reset active low
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  req_hold_a: assert property (
    dma_req_o && !dma_valid_i |=> dma_req_o && $stable(dma_addr_o))
    else $error("request not held");
  req_drop_a: assert property (
    dma_req_o && dma_valid_i |=> !dma_req_o)
    else $error("request not dropped");
  addr_base_a: assert property (
    dma_req_o |-> dma_addr_o[31:17] == 15'h6000 && dma_addr_o[3:0] == 4'h0)
    else $error("fetch address off");
  ctrl_echo_a: assert property (
    ctrl_wr_i |=> ctrl_o == $past(ctrl_data_i))
    else $error("control readback wrong");
  idle_no_req_a: assert property (
    !ctrl_o[31] && !dma_req_o |=> !dma_req_o)
    else $error("request while disabled");
  cp_pulse_a: assert property (
    lcd_cp_o |=> !lcd_cp_o)
    else $error("shift pulse too long");
  lp_with_cp_a: assert property (
    lcd_lp_o |-> lcd_cp_o)
    else $error("line pulse without pixel");
  m_frame_a: assert property (
    $changed(lcd_m_o) |-> lcd_cp_o && lcd_flm_o)
    else $error("bias toggled off frame start");
  data_hold_a: assert property (
    !lcd_cp_o |-> $stable(lcd_data_o))
    else $error("pixel changed without shift");
  underrun_keep_a: assert property (
    underrun_o && !ctrl_wr_i |=> underrun_o)
    else $error("underrun flag lost");
  // Main scenarios reached
  cover property (dma_req_o && dma_valid_i);
  cover property (lcd_lp_o && lcd_flm_o);
  cover property ($rose(underrun_o));
endmodule

bind mlcd_refresh mlcd_refresh_properties i_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .ctrl_wr_i(ctrl_wr_i),
  .ctrl_data_i(ctrl_data_i), .ctrl_o(ctrl_o), .dma_req_o(dma_req_o),
  .dma_addr_o(dma_addr_o), .dma_valid_i(dma_valid_i),
  .lcd_data_o(lcd_data_o), .lcd_cp_o(lcd_cp_o), .lcd_lp_o(lcd_lp_o),
  .lcd_flm_o(lcd_flm_o), .lcd_m_o(lcd_m_o), .underrun_o(underrun_o));

//--- verif/mlcd_panel_model.sv
// Panel stand-in: records every shifted pixel with its markers
`timescale 1ns/1ps
module mlcd_panel_model (
  // Controller clock
  input wire logic clk_i,
  // Panel pins
  input wire logic cp_i,
  input wire logic lp_i,
  input wire logic flm_i,
  input wire logic m_i,
  input wire logic [3:0] data_i
);
  // Captured {bias, first line, line end, gray level}
  logic [6:0] px_q [$];
  // Latch one pixel per shift pulse
  always @(posedge clk_i) begin
    if (cp_i === 1'b1) begin
      px_q.push_back({m_i, flm_i, lp_i, data_i});
    end
  end
endmodule

//--- verif/mlcd_refresh_test.sv
// Self-checking bench for the panel refresh controller
`timescale 1ns/1ps
module mlcd_refresh_test;
  // Clocks, reset, write ports
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic pix_ref_i = 1'b0;
  logic run_ref = 1'b0;
  logic ctrl_wr_i = 1'b0;
  logic palette_lo_wr_i = 1'b0;
  logic palette_hi_wr_i = 1'b0;
  logic [31:0] ctrl_data_i = 32'h0000_0000;
  logic [31:0] palette_data_i = 32'h0000_0000;
  // DMA side and outputs
  logic dma_valid_i = 1'b0;
  logic [31:0] dma_data_i = 32'h0000_0000;
  wire dma_req_o, lcd_cp_o, lcd_lp_o, lcd_flm_o, lcd_m_o, underrun_o;
  wire [31:0] dma_addr_o;
  wire [31:0] ctrl_o;
  wire [3:0] lcd_data_o;
  // Frame memory, palette, counters
  logic [31:0] mem [8];
  logic [63:0] palette;
  logic stall = 1'b1;
  int quad_n = 0;
  int bad_count = 0;
  int samples_checked = 0;

  // System clock 50 MHz
  initial forever #10 clk_i = ~clk_i;
  // Pixel reference clock, 160 ns, only while a run is on
  initial begin
    #3;
    forever #80 pix_ref_i = run_ref ? ~pix_ref_i : 1'b0;
  end

  mlcd_refresh i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_data_i(ctrl_data_i), .palette_lo_wr_i(palette_lo_wr_i),
    .palette_hi_wr_i(palette_hi_wr_i), .palette_data_i(palette_data_i),
    .pix_ref_i(pix_ref_i), .dma_req_o(dma_req_o), .dma_addr_o(dma_addr_o),
    .dma_valid_i(dma_valid_i), .dma_data_i(dma_data_i),
    .lcd_data_o(lcd_data_o), .lcd_cp_o(lcd_cp_o), .lcd_lp_o(lcd_lp_o),
    .lcd_flm_o(lcd_flm_o), .lcd_m_o(lcd_m_o), .underrun_o(underrun_o),
    .ctrl_o(ctrl_o));
  mlcd_panel_model i_panel (
    .clk_i(clk_i), .cp_i(lcd_cp_o), .lp_i(lcd_lp_o), .flm_i(lcd_flm_o),
    .m_i(lcd_m_o), .data_i(lcd_data_o));

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Expected {bias, first line, line end, gray} of pixel n
  function automatic logic [6:0] exp_px(int n, int bpp, int len, int fp);
    int b;
    logic [3:0] v;
    b = (n % fp) * bpp;
    v = 4'((mem[b / 32] >> (b % 32)) & ((1 << bpp) - 1));
    return {(n / fp) % 2 == 0, (n % fp) < len, (n % len) == len - 1,
            palette[v * 4 +: 4]};
  endfunction

  // One write strobe: 0 control, 1 palette low, 2 palette high
  task automatic wr_reg(input int sel, input logic [31:0] d);
    ctrl_wr_i <= (sel == 0);
    palette_lo_wr_i <= (sel == 1);
    palette_hi_wr_i <= (sel == 2);
    ctrl_data_i <= d;
    palette_data_i <= d;
    @(posedge clk_i);
    ctrl_wr_i <= 1'b0;
    palette_lo_wr_i <= 1'b0;
    palette_hi_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Drain bursts, then a short mid-run reset
  task automatic do_reset(input logic s);
    stall <= 1'b1;
    run_ref <= 1'b0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b0;
    // Held past the edge that clears the outputs, so the checker
    // never sees that step with reset already released
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    quad_n = 0;
    stall <= s;
    @(posedge clk_i);
  endtask

  // DMA side: four beats per request, random latency and gaps
  initial begin
    int k;
    forever begin
      @(posedge clk_i);
      if (dma_req_o === 1'b1 && !stall) begin
        check("dma_addr", dma_addr_o, {27'h600_0000, quad_n[0], 4'h0});
        repeat ($urandom % 3) @(posedge clk_i);
        for (k = 0; k < 4; k++) begin
          dma_valid_i <= 1'b1;
          dma_data_i <= mem[quad_n[0] * 4 + k];
          @(posedge clk_i);
          dma_valid_i <= 1'b0;
          dma_data_i <= ~mem[quad_n[0] * 4 + k];
          repeat (1 + $urandom % 2) @(posedge clk_i);
        end
        quad_n++;
      end
    end
  end

  // One depth: random frame data, palette and prescale
  task automatic run_depth(input logic [1:0] d, input logic [5:0] lf);
    logic [31:0] cw;
    logic [4:0] ps;
    int i, bpp, len, fp;
    bpp = (d == 2'h0) ? 1 : (d == 2'h1) ? 2 : 4;
    len = (lf + 1) * 16;
    fp = 256 / bpp;
    ps = 5'($urandom % 3);
    for (i = 0; i < 8; i++) mem[i] = $urandom;
    palette = {$urandom, $urandom};
    do_reset(1'b0);
    wr_reg(1, palette[31:0]);
    wr_reg(2, palette[63:32]);
    cw = {1'b1, 5'h00, d, ps, lf, 13'h0001};
    wr_reg(0, cw);
    check("ctrl_o", ctrl_o, cw);
    repeat (80) @(posedge clk_i);
    i_panel.px_q.delete();
    run_ref <= 1'b1;
    i = 0;
    while (i_panel.px_q.size() < 160 && i < 6000) begin
      @(posedge clk_i);
      i++;
    end
    run_ref <= 1'b0;
    check("pixels", 32'(i_panel.px_q.size()), 32'd160);
    for (i = 0; i < 160; i++) begin
      check("pixel", 32'(i_panel.px_q[i]), 32'(exp_px(i, bpp, len, fp)));
    end
    check("underrun", {31'h0, underrun_o}, 32'h0);
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'hbadc));
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    run_depth(2'h0, 6'h00);
    run_depth(2'h1, 6'h01);
    run_depth(2'h2, 6'h00);
    run_depth(2'h3, 6'h01);
    do_reset(1'b1);
    wr_reg(0, 32'h8000_0001);
    run_ref <= 1'b1;
    repeat (100) @(posedge clk_i);
    run_ref <= 1'b0;
    repeat (20) @(posedge clk_i);
    check("underrun_set", {31'h0, underrun_o}, 32'h1);
    wr_reg(0, 32'h8000_0001);
    check("underrun_clr", {31'h0, underrun_o}, 32'h0);
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end
endmodule
